// ### logic/usb_endpoint_fifo_control.sv
// Purpose: Per-endpoint FIFO control, endpoint configuration and transmit byte port.
// Assumes: Token, receive and transmit strobes are synchronous to clock; one token
//          is decoded at a time and its data packet ends before the next token.
// Notes:   Registers sit at their core-bus addresses; reads answer one cycle later.
`timescale 1ns/10ps
module usb_endpoint_fifo_control
   import uefc_pkg::*;
#(
   parameter int RX_FIFO_DEPTH = UEFC_RX_DEPTH
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Core bus
   input  wire logic [31:0]          busAddr,
   input  wire logic                 busWrite,
   input  wire logic                 busRead,
   input  wire logic [15:0]          busWriteData,
   output logic      [15:0]          busReadData,
   output logic                      busWriteReady,
   // Token decode from the serial engine
   input  wire logic                 tokenValid,
   input  wire uefc_token_t          tokenKind,
   input  wire logic [6:0]           tokenAddress,
   input  wire logic [3:0]           tokenEndpoint,
   input  wire logic [6:0]           deviceAddress,
   // Receive data path
   input  wire logic                 rxByteValid,
   input  wire logic [7:0]           rxByte,
   input  wire logic                 rxPacketEnd,
   input  wire logic                 macReceiving,
   input  wire logic                 rxFifoRead,
   output logic                      rxStoreStrobe,
   output logic      [7:0]           rxStoreData,
   output logic      [$clog2(RX_FIFO_DEPTH):0] rxWritePointer,
   output logic                      receiveSpaceWarning,
   // Transmit data path
   input  wire logic                 txFifoEnabled,
   input  wire logic                 txByteReady,
   output logic                      txByteValid,
   output logic      [7:0]           txByte,
   // Handshake and test
   input  wire logic                 testMode,
   output logic                      handshakeValid,
   output uefc_handshake_t           handshake,
   output logic                      inDataStart
);

   localparam int PTR_W = $clog2(RX_FIFO_DEPTH) + 1;

   typedef struct packed {
      logic              rxEnable;
      logic              setupTokenIgnore;
      logic              flushPending;
      logic [1:0]        receiveWarningLimit;
      logic [3:0]        endpointNumber;
      logic              endpointActive;
      logic              isochronous;
      logic              stall;
      uefc_state_t       state;
      logic              setupSeen;
      logic              dropSetup;
      logic              recvIsSetup;
      logic [PTR_W-1:0]  rxWrPtr;
      logic [PTR_W-1:0]  rxRdPtr;
      logic [15:0]       readData;
      logic [7:0]        lastTxByte;
      logic              rxStore;
      logic [7:0]        rxStoreByte;
      logic              warning;
      logic              hsValid;
      uefc_handshake_t   hsKind;
      logic              inStart;
   } uefc_ctrl_t;

   uefc_ctrl_t s;
   uefc_ctrl_t next_s;

   uefc_stream_if #(.WIDTH(8)) txFill ();
   uefc_stream_if #(.WIDTH(8)) txDrain ();

   // Empty-byte threshold for a limit code; zero width means the warning is off.
   function automatic logic [PTR_W:0] warnThreshold(input logic [1:0] code);
      logic [PTR_W:0] t;
      t = '0;
      unique case (code)
         UEFC_WARN_SMALL: t = (PTR_W+1)'(UEFC_WARN_SMALL_BYTES - 1);
         UEFC_WARN_LARGE: t = (PTR_W+1)'(UEFC_WARN_LARGE_BYTES - 1);
         default:         t = '0;
      endcase
      return t;
   endfunction : warnThreshold

   // Register decode shared by the write and read paths.
   function automatic logic hitReg(input logic [31:0] addr, input logic [31:0] target);
      return addr == target;
   endfunction : hitReg

   logic [PTR_W-1:0] levelNow;
   logic [PTR_W-1:0] spaceNow;
   logic             tokenHit;
   logic             fifoFull;
   logic [15:0]      rxCtrlView;
   logic [15:0]      epCfgView;

   always_comb begin
      levelNow = s.rxWrPtr - s.rxRdPtr;
      spaceNow = PTR_W'(RX_FIFO_DEPTH) - levelNow;
      fifoFull = (levelNow == PTR_W'(RX_FIFO_DEPTH));
      tokenHit = tokenValid && s.endpointActive
                 && (tokenAddress == deviceAddress)
                 && (tokenEndpoint == s.endpointNumber);
      rxCtrlView = '0;
      rxCtrlView[UEFC_RX_EN_BIT]                   = s.rxEnable;
      rxCtrlView[UEFC_IGN_SETUP_BIT]               = s.setupTokenIgnore;
      rxCtrlView[UEFC_FLUSH_BIT]                   = s.flushPending;
      rxCtrlView[UEFC_WARN_MSB:UEFC_WARN_LSB]      = s.receiveWarningLimit;
      epCfgView  = '0;
      epCfgView[UEFC_EPNUM_MSB:UEFC_EPNUM_LSB]     = s.endpointNumber;
      epCfgView[UEFC_EP_ACTIVE_BIT]                = s.endpointActive;
      epCfgView[UEFC_ISO_BIT]                      = s.isochronous;
      epCfgView[UEFC_STALL_BIT]                    = s.stall;
   end

   // Transmit byte port feeds the buffer; the serial engine adds PID and CRC16.
   assign txFill.valid = busWrite && hitReg(busAddr, UEFC_TXDATA_ADDR);
   assign txFill.data  = busWriteData[UEFC_TXBYTE_MSB:UEFC_TXBYTE_LSB];
   assign txDrain.ready = txByteReady;

   uefc_skid_buffer #(.WIDTH(8)) txBuffer (
      .clock (clock),
      .rst   (rst),
      .fill  (txFill.sink),
      .drain (txDrain.source)
   );

   always_comb begin
      next_s         = s;
      next_s.rxStore = 1'b0;
      next_s.hsValid = 1'b0;
      next_s.hsKind  = HS_NONE;
      next_s.inStart = 1'b0;

      // Firmware consumes receive bytes from the far end of the FIFO.
      if (rxFifoRead && levelNow != '0) begin
         next_s.rxRdPtr = s.rxRdPtr + PTR_W'(1);
      end

      unique case (s.state)
         ST_IDLE: begin
            if (tokenHit) begin
               unique case (tokenKind)
                  TOK_SETUP: begin
                     // The stall bit plays no part on this path.
                     if (s.setupTokenIgnore) begin
                        next_s.hsValid = 1'b0;
                     end else if (s.setupSeen) begin
                        next_s.state       = ST_RECV;
                        next_s.dropSetup   = 1'b1;
                        next_s.recvIsSetup = 1'b1;
                     end else if (s.flushPending || fifoFull) begin
                        next_s.hsValid = 1'b0;
                     end else begin
                        next_s.state       = ST_RECV;
                        next_s.dropSetup   = 1'b0;
                        next_s.recvIsSetup = 1'b1;
                     end
                  end
                  TOK_OUT: begin
                     next_s.setupSeen = 1'b0;
                     if (s.stall && s.rxEnable) begin
                        next_s.hsValid  = 1'b1;
                        next_s.hsKind   = HS_STALL;
                        next_s.rxEnable = 1'b0;
                     end else if (!s.rxEnable || fifoFull || s.flushPending) begin
                        next_s.hsValid = !s.isochronous;
                        next_s.hsKind  = HS_NAK;
                     end else begin
                        next_s.state       = ST_RECV;
                        next_s.dropSetup   = 1'b0;
                        next_s.recvIsSetup = 1'b0;
                     end
                  end
                  TOK_IN: begin
                     next_s.setupSeen = 1'b0;
                     if (s.stall && txFifoEnabled) begin
                        next_s.hsValid = 1'b1;
                        next_s.hsKind  = HS_STALL;
                     end else if (!txDrain.valid) begin
                        next_s.hsValid = !s.isochronous;
                        next_s.hsKind  = HS_NAK;
                     end else begin
                        next_s.inStart = 1'b1;
                     end
                  end
                  default: begin
                     next_s.setupSeen = 1'b0;
                  end
               endcase
            end
         end
         ST_RECV: begin
            // Bytes beyond capacity are lost rather than wrapping the pointers.
            if (rxByteValid && !s.dropSetup && !fifoFull) begin
               next_s.rxStore     = 1'b1;
               next_s.rxStoreByte = rxByte;
               next_s.rxWrPtr     = s.rxWrPtr + PTR_W'(1);
            end
            if (rxPacketEnd) begin
               next_s.state    = ST_IDLE;
               next_s.hsValid  = !s.isochronous || s.recvIsSetup;
               next_s.hsKind   = HS_ACK;
               next_s.rxEnable = 1'b0;
               if (s.recvIsSetup) begin
                  next_s.setupSeen = 1'b1;
               end
               next_s.dropSetup = 1'b0;
            end
         end
      endcase

      // A flush waits for both the local packet and the serial engine to finish.
      if (s.flushPending && s.state == ST_IDLE && !macReceiving) begin
         next_s.rxWrPtr      = '0;
         next_s.rxRdPtr      = '0;
         next_s.state        = ST_IDLE;
         next_s.dropSetup    = 1'b0;
         next_s.flushPending = 1'b0;
      end

      // Software writes land last, so a set from software beats a hardware clear.
      if (busWrite && hitReg(busAddr, UEFC_RXCTRL_ADDR)) begin
         if (busWriteData[UEFC_RX_EN_BIT]) begin
            next_s.rxEnable = 1'b1;
         end
         if (busWriteData[UEFC_FLUSH_BIT]) begin
            next_s.flushPending = 1'b1;
         end
         next_s.setupTokenIgnore    = busWriteData[UEFC_IGN_SETUP_BIT];
         next_s.receiveWarningLimit = busWriteData[UEFC_WARN_MSB:UEFC_WARN_LSB];
      end
      if (busWrite && hitReg(busAddr, UEFC_EPCFG_ADDR)) begin
         next_s.endpointNumber = busWriteData[UEFC_EPNUM_MSB:UEFC_EPNUM_LSB];
         next_s.endpointActive = busWriteData[UEFC_EP_ACTIVE_BIT];
         next_s.isochronous    = busWriteData[UEFC_ISO_BIT];
         next_s.stall          = busWriteData[UEFC_STALL_BIT];
      end
      if (txFill.valid && txFill.ready) begin
         next_s.lastTxByte = txFill.data;
      end

      // Warning level follows the FIFO space against the chosen limit.
      next_s.warning = (s.receiveWarningLimit == UEFC_WARN_SMALL
                        || s.receiveWarningLimit == UEFC_WARN_LARGE)
                       && ({1'b0, spaceNow} <= warnThreshold(s.receiveWarningLimit));

      next_s.readData = '0;
      if (busRead) begin
         if (hitReg(busAddr, UEFC_RXCTRL_ADDR)) begin
            next_s.readData = rxCtrlView & UEFC_RXCTRL_MASK;
         end else if (hitReg(busAddr, UEFC_EPCFG_ADDR)) begin
            next_s.readData = epCfgView & UEFC_EPCFG_MASK;
         end else if (hitReg(busAddr, UEFC_TXDATA_ADDR) && testMode) begin
            next_s.readData = {8'h00, s.lastTxByte} & UEFC_TXDATA_MASK;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s       <= '0;
         s.state <= ST_IDLE;
         s.hsKind <= HS_NONE;
      end else begin
         s <= next_s;
      end
   end

   assign busReadData         = s.readData;
   assign busWriteReady       = txFill.ready;
   assign rxStoreStrobe       = s.rxStore;
   assign rxStoreData         = s.rxStoreByte;
   assign rxWritePointer      = s.rxWrPtr;
   assign receiveSpaceWarning = s.warning;
   assign txByteValid         = txDrain.valid;
   assign txByte              = txDrain.data;
   assign handshakeValid      = s.hsValid;
   assign handshake           = s.hsKind;
   assign inDataStart         = s.inStart;

endmodule : usb_endpoint_fifo_control

// ### logic/uefc_pkg.sv
// Purpose: Shared constants and types for the USB endpoint FIFO control block.
// Assumes: Registers are 16 bits wide and sit at their own core-bus addresses.
// Notes:   Field masks list the bits that software may write; all others read zero.
package uefc_pkg;

   // Register addresses on the core bus.
   localparam logic [31:0] UEFC_RXCTRL_ADDR   = 32'h5000_186E;
   localparam logic [31:0] UEFC_EPCFG_ADDR    = 32'h5000_1870;
   localparam logic [31:0] UEFC_TXDATA_ADDR   = 32'h5000_1872;

   localparam logic [15:0] UEFC_REG_RESET     = 16'h0000;
   localparam logic [15:0] UEFC_RXCTRL_MASK   = 16'h006D;
   localparam logic [15:0] UEFC_EPCFG_MASK    = 16'h00BF;
   localparam logic [15:0] UEFC_TXDATA_MASK   = 16'h00FF;

   // Receive endpoint control fields.
   localparam int          UEFC_RX_EN_BIT     = 0;
   localparam int          UEFC_IGN_SETUP_BIT = 2;
   localparam int          UEFC_FLUSH_BIT     = 3;
   localparam int          UEFC_WARN_LSB      = 5;
   localparam int          UEFC_WARN_MSB      = 6;

   // Endpoint configuration fields.
   localparam int          UEFC_EPNUM_LSB     = 0;
   localparam int          UEFC_EPNUM_MSB     = 3;
   localparam int          UEFC_EP_ACTIVE_BIT = 4;
   localparam int          UEFC_ISO_BIT       = 5;
   localparam int          UEFC_STALL_BIT     = 7;

   // Transmit byte port field.
   localparam int          UEFC_TXBYTE_LSB    = 0;
   localparam int          UEFC_TXBYTE_MSB    = 7;

   // Receive warning limit codes and their byte figures.
   localparam logic [1:0]  UEFC_WARN_OFF      = 2'h0;
   localparam logic [1:0]  UEFC_WARN_SMALL    = 2'h1;
   localparam logic [1:0]  UEFC_WARN_LARGE    = 2'h2;
   localparam int          UEFC_WARN_SMALL_BYTES = 5;
   localparam int          UEFC_WARN_LARGE_BYTES = 17;

   localparam int          UEFC_RX_DEPTH      = 64;

   typedef enum logic [1:0] {
      TOK_OUT   = 2'b00,
      TOK_IN    = 2'b01,
      TOK_SETUP = 2'b10,
      TOK_OTHER = 2'b11
   } uefc_token_t;

   typedef enum logic [1:0] {
      HS_NONE  = 2'b00,
      HS_ACK   = 2'b01,
      HS_NAK   = 2'b10,
      HS_STALL = 2'b11
   } uefc_handshake_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01
   } uefc_state_t;

endpackage : uefc_pkg

// ### logic/uefc_stream_if.sv
// Purpose: Valid/ready byte stream between the block's own modules.
// Assumes: A word moves on a clock edge where valid and ready are both high.
// Notes:   Used only inside the block; the top keeps plain ports.
`timescale 1ns/10ps
interface uefc_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : uefc_stream_if

// ### logic/uefc_skid_buffer.sv
// Purpose: Two-entry buffer in the transmit byte path.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Output data and both valid/ready flags come straight from flip-flops.
`timescale 1ns/10ps
module uefc_skid_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  rst,
   // Filling side
   uefc_stream_if.sink   fill,
   // Draining side
   uefc_stream_if.source drain
);

   typedef struct packed {
      logic [WIDTH-1:0] head;
      logic             headValid;
      logic [WIDTH-1:0] tail;
      logic             tailValid;
   } uefc_buf_t;

   uefc_buf_t s;
   uefc_buf_t next_s;

   always_comb begin
      next_s = s;
      if (s.headValid && drain.ready) begin
         next_s.headValid = 1'b0;
         if (s.tailValid) begin
            next_s.head      = s.tail;
            next_s.headValid = 1'b1;
            next_s.tailValid = 1'b0;
         end
      end
      // Ready is the registered "tail empty", so a word offered now always has a slot.
      if (fill.valid && !s.tailValid) begin
         if (!next_s.headValid) begin
            next_s.head      = fill.data;
            next_s.headValid = 1'b1;
         end else begin
            next_s.tail      = fill.data;
            next_s.tailValid = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign fill.ready  = !s.tailValid;
   assign drain.valid = s.headValid;
   assign drain.data  = s.head;

endmodule : uefc_skid_buffer

// ### tb/uefc_monitor.sv
// Purpose: Port-level checks for the endpoint FIFO control block.
// Assumes: Shadow of the endpoint setup follows core-bus writes.
// Notes:   No token is sent in the cycle that rewrites the endpoint setup.
`timescale 1ns/10ps
module uefc_monitor
   import uefc_pkg::*;
#(
   parameter int RX_FIFO_DEPTH = UEFC_RX_DEPTH
) (
   // Clock and reset
   input wire logic            clock,
   input wire logic            rst,
   // Core bus
   input wire logic [31:0]     busAddr,
   input wire logic            busWrite,
   input wire logic            busRead,
   input wire logic [15:0]     busWriteData,
   input wire logic [15:0]     busReadData,
   input wire logic            busWriteReady,
   // Tokens and answers
   input wire logic            tokenValid,
   input wire uefc_token_t     tokenKind,
   input wire logic [6:0]      tokenAddress,
   input wire logic [3:0]      tokenEndpoint,
   input wire logic [6:0]      deviceAddress,
   input wire logic            handshakeValid,
   input wire uefc_handshake_t handshake,
   input wire logic            inDataStart,
   // Transmit path
   input wire logic            testMode,
   input wire logic            txByteReady,
   input wire logic            txByteValid,
   input wire logic [7:0]      txByte
);
   logic [7:0] epCfg;
   logic [7:0] lastWrite;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         epCfg <= 8'h00;
         lastWrite <= 8'h00;
      end else begin
         lastWrite <= busWriteData[7:0];
         if (busWrite && busAddr == UEFC_EPCFG_ADDR) begin
            epCfg <= busWriteData[7:0] & 8'hBF;
         end
      end
   end

   default clocking mcb @(posedge clock);
   endclocking
   default disable iff (rst);

   AST_RX_RESERVED: assert property (
      busRead && busAddr == UEFC_RXCTRL_ADDR |=> (busReadData & ~UEFC_RXCTRL_MASK) == 16'h0000)
      else $error("receive control reserved bits not zero");
   AST_EP_READBACK: assert property (
      busRead && busAddr == UEFC_EPCFG_ADDR |=> busReadData == {8'h00, $past(epCfg)})
      else $error("endpoint setup read back wrong");
   AST_TX_NOREAD: assert property (
      busRead && busAddr == UEFC_TXDATA_ADDR && !testMode |=> busReadData == 16'h0000)
      else $error("transmit port readable outside test mode");
   AST_STALL_SETUP: assert property (
      handshakeValid && handshake == HS_STALL |-> $past(tokenValid) && $past(tokenKind) != TOK_SETUP)
      else $error("stall sent for a setup token");
   AST_ISO_NAK: assert property (
      handshakeValid |-> !(epCfg[5] && handshake == HS_NAK))
      else $error("isochronous endpoint sent a nak");
   AST_DISABLED: assert property (
      tokenValid && !epCfg[4] |=> !handshakeValid && !inDataStart)
      else $error("disabled endpoint answered a token");
   AST_MISMATCH: assert property (
      tokenValid && (tokenAddress != deviceAddress || tokenEndpoint != epCfg[3:0])
      |=> !handshakeValid && !inDataStart) else $error("foreign token answered");
   AST_TX_LOAD: assert property (
      busWrite && busAddr == UEFC_TXDATA_ADDR && busWriteReady && !txByteValid
      |=> txByteValid && txByte == lastWrite) else $error("transmit byte not loaded");
   AST_TX_HOLD: assert property (
      txByteValid && !txByteReady |=> txByteValid && $stable(txByte))
      else $error("transmit byte lost during stall");
endmodule : uefc_monitor

bind usb_endpoint_fifo_control uefc_monitor #(.RX_FIFO_DEPTH(RX_FIFO_DEPTH)) u_mon (
   .clock, .rst, .busAddr, .busWrite, .busRead, .busWriteData, .busReadData,
   .busWriteReady, .tokenValid, .tokenKind, .tokenAddress, .tokenEndpoint,
   .deviceAddress, .handshakeValid, .handshake, .inDataStart, .testMode,
   .txByteReady, .txByteValid, .txByte);

// ### tb/uefc_host_model.sv
// Purpose: Host side of the serial engine: tokens, payload bytes, transmit drain.
// Assumes: Every output changes at the falling edge of clock.
// Notes:   The transmit side stalls unless a drain is running.
`timescale 1ns/10ps
module uefc_host_model
   import uefc_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Tokens
   output logic            tokenValid,
   output uefc_token_t     tokenKind,
   output logic [6:0]      tokenAddress,
   output logic [3:0]      tokenEndpoint,
   // Receive bytes
   output logic            rxByteValid,
   output logic [7:0]      rxByte,
   output logic            rxPacketEnd,
   output logic            macReceiving,
   // Transmit bytes
   output logic            txByteReady,
   input  wire logic       txByteValid,
   input  wire logic [7:0] txByte
);
   initial begin
      {tokenValid, rxByteValid, rxPacketEnd, macReceiving, txByteReady} = 5'h00;
      tokenKind = TOK_OTHER;
      {tokenAddress, tokenEndpoint, rxByte} = 19'h0_0000;
   end

   task automatic token(input uefc_token_t k, input logic [6:0] a, input logic [3:0] e);
      @(negedge clock);
      {tokenValid, tokenKind, tokenAddress, tokenEndpoint} = {1'b1, k, a, e};
      @(negedge clock);
      // Stale fields are inverted so nothing can match them by accident.
      {tokenValid, tokenAddress, tokenEndpoint} = {1'b0, ~a, ~e};
   endtask : token

   task automatic data(input int n);
      macReceiving = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         {rxByteValid, rxByte} = {1'b1, 8'(i) ^ 8'hA5};
         @(negedge clock);
         {rxByteValid, rxByte} = {1'b0, ~rxByte};
      end
   endtask : data

   task automatic finish();
      @(negedge clock);
      {rxPacketEnd, macReceiving} = 2'h2;
      @(negedge clock);
      rxPacketEnd = 1'b0;
   endtask : finish

   task automatic drain(output logic [7:0] q[$]);
      @(negedge clock);
      txByteReady = 1'b1;
      repeat (6) begin
         if (txByteValid === 1'b1) q.push_back(txByte);
         @(negedge clock);
      end
      txByteReady = 1'b0;
   endtask : drain
endmodule : uefc_host_model

// ### tb/usb_endpoint_fifo_control_tb_top.sv
// Purpose: Self-checking bench for the endpoint FIFO control block.
// Assumes: Bench drives at the falling edge; the host model stands at the serial side.
// Notes:   A 20-byte receive FIFO keeps both warning boundaries close together.
`timescale 1ns/10ps
module usb_endpoint_fifo_control_tb_top
   import uefc_pkg::*;
;
   localparam logic [6:0]  DEV = 7'h25;
   localparam logic [3:0]  EPN = 4'h3;
   localparam logic [31:0] RXC = UEFC_RXCTRL_ADDR;
   localparam logic [31:0] EPC = UEFC_EPCFG_ADDR;
   localparam logic [31:0] TXD = UEFC_TXDATA_ADDR;
   logic            clock, rst, busWrite, busRead, busWriteReady, tokenValid, rxByteValid;
   logic            rxPacketEnd, macReceiving, receiveSpaceWarning, txByteReady;
   logic            txByteValid, handshakeValid, inDataStart, testMode;
   logic [31:0]     busAddr;
   logic [15:0]     busWriteData, busReadData;
   logic [6:0]      tokenAddress;
   logic [3:0]      tokenEndpoint;
   logic [7:0]      rxByte, txByte;
   logic [5:0]      rxWritePointer;
   uefc_token_t     tokenKind;
   uefc_handshake_t handshake;
   logic [7:0]      got[$];
   int              failures = 0, cmpCount = 0, cycles = 0;
   int              sizes[4] = '{3, 1, 11, 1};
   logic [3:0]      warnExp[4] = '{4'h0, 4'h4, 4'h4, 4'h6};

   usb_endpoint_fifo_control #(.RX_FIFO_DEPTH(20)) u_dut (
      .clock, .rst, .busAddr, .busWrite, .busRead, .busWriteData, .busReadData,
      .busWriteReady, .tokenValid, .tokenKind, .tokenAddress, .tokenEndpoint,
      .deviceAddress(DEV), .rxByteValid, .rxByte, .rxPacketEnd, .macReceiving,
      .rxFifoRead(1'b0), .rxStoreStrobe(), .rxStoreData(), .rxWritePointer,
      .receiveSpaceWarning, .txFifoEnabled(1'b1), .txByteReady, .txByteValid,
      .txByte, .testMode, .handshakeValid, .handshake, .inDataStart);
   uefc_host_model u_host (.clock, .tokenValid, .tokenKind, .tokenAddress, .tokenEndpoint,
      .rxByteValid, .rxByte, .rxPacketEnd, .macReceiving, .txByteReady, .txByteValid, .txByte);

   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         results();
      end
   end

   task automatic results();
      $display("compares %0d failures %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string msg);
      cmpCount = cmpCount + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, g, e);
      end
   endtask : chk16

   task automatic chkHs(input uefc_handshake_t e);
      uefc_handshake_t seen;
      seen = HS_NONE;
      repeat (4) begin
         if (handshakeValid === 1'b1) seen = handshake;
         @(negedge clock);
      end
      chk16(16'(seen), 16'(e), "handshake");
   endtask : chkHs

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(negedge clock);
      {busAddr, busWriteData, busWrite} = {a, d, 1'b1};
      @(negedge clock);
      busWrite = 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      @(negedge clock);
      {busAddr, busRead} = {a, 1'b1};
      @(negedge clock);
      busRead = 1'b0;
      chk16(busReadData, e, "register read");
   endtask : rd

   task automatic pkt(input uefc_token_t k, input int n, input uefc_handshake_t e);
      u_host.token(k, DEV, EPN);
      u_host.data(n);
      u_host.finish();
      chkHs(e);
   endtask : pkt

   initial begin
      {testMode, busAddr, busWriteData, busWrite, busRead, rst} = 52'h1;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      rd(RXC, UEFC_REG_RESET);
      rd(EPC, UEFC_REG_RESET);
      rd(TXD, UEFC_REG_RESET);
      wr(EPC, 16'hFFFF);
      rd(EPC, UEFC_EPCFG_MASK);
      wr(RXC, 16'hFFF7);
      rd(RXC, 16'h0065);
      wr(32'h5000_1880, 16'hFFFF);
      rd(32'h5000_1880, 16'h0000);
      wr(EPC, 16'h0013);
      for (int i = 0; i < 4; i++) begin
         wr(RXC, 16'h0001);
         pkt(TOK_OUT, sizes[i], HS_ACK);
         rd(RXC, 16'h0000);
         for (int c = 0; c < 4; c++) begin
            wr(RXC, {9'h000, c[1:0], 5'h00});
            repeat (2) @(negedge clock);
            chk16(16'(receiveSpaceWarning), 16'(warnExp[i][c]), "warning");
         end
      end
      // Flush is requested while the engine is still storing a packet.
      wr(RXC, 16'h0001);
      u_host.token(TOK_OUT, DEV, EPN);
      u_host.data(2);
      wr(RXC, 16'h0009);
      rd(RXC, 16'h0009);
      chk16(16'(rxWritePointer), 16'h0012, "pointer before flush");
      u_host.finish();
      chkHs(HS_ACK);
      repeat (4) @(negedge clock);
      rd(RXC, 16'h0000);
      chk16(16'(rxWritePointer), 16'h0000, "pointer after flush");
      u_host.token(TOK_OUT, DEV, EPN);
      chkHs(HS_NAK);
      pkt(TOK_SETUP, 8, HS_ACK);
      pkt(TOK_SETUP, 8, HS_ACK);
      chk16(16'(rxWritePointer), 16'h0008, "repeat setup dropped");
      wr(RXC, 16'h0004);
      pkt(TOK_SETUP, 8, HS_NONE);
      chk16(16'(rxWritePointer), 16'h0008, "ignored setup");
      wr(RXC, 16'h0001);
      wr(EPC, 16'h0093);
      u_host.token(TOK_IN, DEV, EPN);
      chkHs(HS_STALL);
      u_host.token(TOK_OUT, DEV, EPN);
      chkHs(HS_STALL);
      rd(RXC, 16'h0000);
      pkt(TOK_SETUP, 8, HS_ACK);
      wr(EPC, 16'h0033);
      u_host.token(TOK_IN, DEV, EPN);
      chkHs(HS_NONE);
      u_host.token(TOK_OUT, DEV, EPN);
      chkHs(HS_NONE);
      wr(EPC, 16'h0003);
      u_host.token(TOK_IN, DEV, EPN);
      chkHs(HS_NONE);
      wr(EPC, 16'h0013);
      u_host.token(TOK_IN, DEV, 4'h4);
      chkHs(HS_NONE);
      u_host.token(TOK_IN, 7'h26, EPN);
      chkHs(HS_NONE);
      u_host.token(TOK_IN, DEV, EPN);
      chkHs(HS_NAK);
      // Only payload bytes go to the port; the upper byte must be dropped.
      wr(TXD, 16'hAB11);
      wr(TXD, 16'hCD22);
      chk16(16'(busWriteReady), 16'h0000, "buffer full");
      wr(TXD, 16'hEF33);
      u_host.token(TOK_IN, DEV, EPN);
      chk16(16'(inDataStart), 16'h0001, "data start");
      rd(TXD, 16'h0000);
      u_host.drain(got);
      chk16(16'(got.size()), 16'h0002, "drained count");
      chk16({got[0], got[1]}, 16'h1122, "drained bytes");
      chk16(16'(busWriteReady), 16'h0001, "buffer empty");
      testMode = 1'b1;
      rd(TXD, 16'h0022);
      results();
   end
endmodule : usb_endpoint_fifo_control_tb_top
